/* File: pmc_top.sv */
// Function
// - Active: core regulator on, CPU runs, fast oscillator and one slow source.
// - CPU idle keeps oscillators and regulator as active, CPU executes nothing.
// - Light sleep: regulator on, fast oscillators off; wake on ext or timer.
// - Deep sleep: regulator off, fast oscillators off; wake on ext or timer.
// - Lowest power: regulator and all oscillators off; wake on ext only.
// - Deep and lowest modes discard USB state; avoid them while USB runs.
// - Wake from sleep by ext or timer resumes execution where it stopped.
// - Any enabled interrupt ends CPU idle and execution continues in place.
// - Reset from any mode restarts the program from its beginning.
// - Idle request in active mode with CPU idle selected gates CPU clock until an interrupt, ext wake or timer.
// - Light sleep stops fast oscillators; wake logic and slow source stay.
// - During light sleep all pins hold direction and level from before.
// - Short power-down sequence on light sleep entry, power-up on exit.
// - Software picks the mode first, then sets the idle request bit.
// - Hardware clears the sleep-mode field when a power mode is entered.
// - Wake from sleep clears sleep-mode field and the idle request.
// - After wake on crystal select, run on fast RC until crystal stable.
`timescale 1ns/1ps

module pmc_top #(
    parameter int SEQ_W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_irq_any,
    input wire logic i_ext_wake,
    input wire logic i_sleep_timer_expired,
    input wire logic i_crystal_stable_flag,
    output pmc_pkg::pmc_enables_t o_en,
    output logic o_sys_clk_on_crystal,
    output logic o_io_hold,
    output logic o_usb_reset,
    output logic o_cpu_resume,
    output logic o_cpu_restart,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr
);

    ////////////////////////////////////////////////////////////////////////
    // Pin-side inputs cross into the system clock
    logic [2:0] pins_s;
    logic ext_wake_s;
    logic timer_s;
    logic xstb_s;

    pmc_sync #(
        .W(3)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async({i_ext_wake, i_sleep_timer_expired, i_crystal_stable_flag}),
        .o_sync(pins_s)
    );

    assign ext_wake_s = pins_s[2];
    assign timer_s = pins_s[1];
    assign xstb_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////
    // State
    pmc_pkg::pmc_state_t state;
    pmc_pkg::pmc_state_t next_state;
    logic [1:0] target;
    logic [1:0] next_target;
    logic [1:0] sleep_mode;
    logic [1:0] next_sleep_mode;
    logic clk_src_sel;
    logic next_clk_src_sel;
    logic slow_src_sel;
    logic next_slow_src_sel;
    logic usb_en;
    logic next_usb_en;
    pmc_pkg::pmc_enables_t next_en;
    logic next_on_crystal;
    logic next_io_hold;
    logic next_usb_reset;
    logic next_cpu_resume;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic seq_start;
    logic [SEQ_W-1:0] seq_load;
    logic seq_done;
    logic wr_take;
    logic idle_req;
    logic [31:0] ctrl_rd;
    logic [31:0] status_rd;

    pmc_seq_cnt #(
        .W(SEQ_W)
    ) u_seq (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_start(seq_start),
        .i_load(seq_load),
        .o_done(seq_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, write takes effect on the completing edge
    assign wr_take = i_psel && i_penable && o_pready && i_pwrite
        && (i_paddr == pmc_pkg::CTRL_OFFSET);
    // Idle request is a write-one strobe; it always reads back as zero
    assign idle_req = wr_take && i_pwdata[pmc_pkg::CTRL_IDLE_BIT];

    always_comb
    begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[pmc_pkg::CTRL_MODE_LSB +: 2] = sleep_mode;
        ctrl_rd[pmc_pkg::CTRL_CLKSRC_BIT] = clk_src_sel;
        ctrl_rd[pmc_pkg::CTRL_SLOWSRC_BIT] = slow_src_sel;
        ctrl_rd[pmc_pkg::CTRL_USB_BIT] = usb_en;
        status_rd = 32'h0000_0000;
        status_rd[pmc_pkg::STAT_MODE_LSB +: 3] = state;
        status_rd[pmc_pkg::STAT_XSTB_BIT] = xstb_s;
        status_rd[pmc_pkg::STAT_CPUGATE_BIT] = ~o_en.cpu_clk;
        status_rd[pmc_pkg::STAT_ONXTAL_BIT] = o_sys_clk_on_crystal;
        status_rd[pmc_pkg::STAT_IOHOLD_BIT] = o_io_hold;
    end

    always_comb
    begin
        next_pready = 1'b0;
        next_prdata = o_prdata;
        next_pslverr = 1'b0;
        if (i_psel && i_penable && !o_pready)
        begin
            next_pready = 1'b1;
            if (i_paddr == pmc_pkg::CTRL_OFFSET)
            begin
                next_prdata = ctrl_rd;
            end
            else if (i_paddr == pmc_pkg::STATUS_OFFSET)
            begin
                next_prdata = status_rd;
            end
            else
            begin
                next_prdata = 32'h0000_0000;
                next_pslverr = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    always_comb
    begin
        next_state = state;
        next_target = target;
        next_sleep_mode = sleep_mode;
        next_clk_src_sel = clk_src_sel;
        next_slow_src_sel = slow_src_sel;
        next_usb_en = usb_en;
        next_usb_reset = 1'b0;
        next_cpu_resume = 1'b0;
        seq_start = 1'b0;
        seq_load = SEQ_W'(pmc_pkg::SEQ_FAST_CYC);
        if (wr_take)
        begin
            next_sleep_mode = i_pwdata[pmc_pkg::CTRL_MODE_LSB +: 2];
            next_clk_src_sel = i_pwdata[pmc_pkg::CTRL_CLKSRC_BIT];
            next_slow_src_sel = i_pwdata[pmc_pkg::CTRL_SLOWSRC_BIT];
            next_usb_en = i_pwdata[pmc_pkg::CTRL_USB_BIT];
        end
        unique case (state)
            pmc_pkg::PMC_ACTIVE:
            begin
                // Mode already held in the field when the request lands
                if (idle_req)
                begin
                    if (sleep_mode == pmc_pkg::SEL_CPU_IDLE)
                    begin
                        next_state = pmc_pkg::PMC_CPU_IDLE;
                    end
                    else
                    begin
                        next_target = sleep_mode;
                        seq_start = 1'b1;
                        if (sleep_mode != pmc_pkg::SEL_LIGHT)
                        begin
                            seq_load = SEQ_W'(pmc_pkg::SEQ_SLOW_CYC);
                        end
                        next_state = pmc_pkg::PMC_PWR_DOWN;
                    end
                end
            end
            pmc_pkg::PMC_CPU_IDLE:
            begin
                if (i_irq_any || ext_wake_s || timer_s)
                begin
                    next_state = pmc_pkg::PMC_ACTIVE;
                    next_cpu_resume = 1'b1;
                end
            end
            pmc_pkg::PMC_PWR_DOWN:
            begin
                if (seq_done)
                begin
                    next_sleep_mode = pmc_pkg::SEL_CPU_IDLE;
                    unique case (target)
                        pmc_pkg::SEL_LIGHT: next_state = pmc_pkg::PMC_LIGHT;
                        pmc_pkg::SEL_DEEP: next_state = pmc_pkg::PMC_DEEP;
                        default: next_state = pmc_pkg::PMC_LOWEST;
                    endcase
                    if (target != pmc_pkg::SEL_LIGHT)
                    begin
                        // Core power drops, so USB state cannot survive
                        next_usb_en = 1'b0;
                        next_usb_reset = 1'b1;
                    end
                end
            end
            pmc_pkg::PMC_LIGHT:
            begin
                if (ext_wake_s || timer_s)
                begin
                    seq_start = 1'b1;
                    next_state = pmc_pkg::PMC_PWR_UP;
                end
            end
            pmc_pkg::PMC_DEEP:
            begin
                if (ext_wake_s || timer_s)
                begin
                    seq_start = 1'b1;
                    seq_load = SEQ_W'(pmc_pkg::SEQ_SLOW_CYC);
                    next_state = pmc_pkg::PMC_PWR_UP;
                end
            end
            pmc_pkg::PMC_LOWEST:
            begin
                // Sleep timer has no clock here, only the pin can wake
                if (ext_wake_s)
                begin
                    seq_start = 1'b1;
                    seq_load = SEQ_W'(pmc_pkg::SEQ_SLOW_CYC);
                    next_state = pmc_pkg::PMC_PWR_UP;
                end
            end
            pmc_pkg::PMC_PWR_UP:
            begin
                if (seq_done)
                begin
                    next_sleep_mode = pmc_pkg::SEL_CPU_IDLE;
                    next_state = pmc_pkg::PMC_ACTIVE;
                    next_cpu_resume = 1'b1;
                end
            end
            default:
            begin
                next_state = pmc_pkg::PMC_ACTIVE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables from the mode
    always_comb
    begin
        logic awake;
        logic slow_on;
        awake = (state == pmc_pkg::PMC_ACTIVE) || (state == pmc_pkg::PMC_CPU_IDLE)
            || (state == pmc_pkg::PMC_PWR_DOWN) || (state == pmc_pkg::PMC_PWR_UP);
        slow_on = (next_state != pmc_pkg::PMC_LOWEST);
        next_en.core_reg = (next_state != pmc_pkg::PMC_DEEP)
            && (next_state != pmc_pkg::PMC_LOWEST);
        next_en.crystal = awake && (next_state != pmc_pkg::PMC_LIGHT)
            && (next_state != pmc_pkg::PMC_DEEP) && (next_state != pmc_pkg::PMC_LOWEST)
            && (next_clk_src_sel == pmc_pkg::CLKSRC_CRYSTAL);
        // Fast RC always runs while awake so there is a clock to fall back on
        next_en.fast_rc = awake && (next_state != pmc_pkg::PMC_LIGHT)
            && (next_state != pmc_pkg::PMC_DEEP)
            && (next_state != pmc_pkg::PMC_LOWEST);
        next_en.slow_rc = slow_on && (next_slow_src_sel == pmc_pkg::SLOWSRC_RC);
        next_en.crystal_32k = slow_on && (next_slow_src_sel != pmc_pkg::SLOWSRC_RC);
        next_en.cpu_clk = (next_state == pmc_pkg::PMC_ACTIVE);
        next_on_crystal = (state == pmc_pkg::PMC_ACTIVE || state == pmc_pkg::PMC_CPU_IDLE)
            && (clk_src_sel == pmc_pkg::CLKSRC_CRYSTAL) && o_en.crystal && xstb_s;
        next_io_hold = (next_state == pmc_pkg::PMC_LIGHT) || (next_state == pmc_pkg::PMC_DEEP)
            || (next_state == pmc_pkg::PMC_LOWEST);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= pmc_pkg::PMC_ACTIVE;
            target <= pmc_pkg::SEL_CPU_IDLE;
            sleep_mode <= pmc_pkg::MODE_RESET;
            clk_src_sel <= pmc_pkg::CLKSRC_RESET;
            slow_src_sel <= pmc_pkg::SLOWSRC_RESET;
            usb_en <= pmc_pkg::USB_RESET;
            o_en <= pmc_pkg::EN_RESET;
            o_sys_clk_on_crystal <= 1'b0;
            o_io_hold <= 1'b0;
            o_usb_reset <= 1'b0;
            o_cpu_resume <= 1'b0;
            o_cpu_restart <= 1'b1;
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            state <= next_state;
            target <= next_target;
            sleep_mode <= next_sleep_mode;
            clk_src_sel <= next_clk_src_sel;
            slow_src_sel <= next_slow_src_sel;
            usb_en <= next_usb_en;
            o_en <= next_en;
            o_sys_clk_on_crystal <= next_on_crystal;
            o_io_hold <= next_io_hold;
            o_usb_reset <= next_usb_reset;
            o_cpu_resume <= next_cpu_resume;
            o_cpu_restart <= 1'b0;
            o_pready <= next_pready;
            o_prdata <= next_prdata;
            o_pslverr <= next_pslverr;
        end
    end

endmodule : pmc_top

/* File: pmc_pkg.sv */
package pmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on APB
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_IDLE_BIT = 2;
    localparam int CTRL_CLKSRC_BIT = 3;
    localparam int CTRL_SLOWSRC_BIT = 4;
    localparam int CTRL_USB_BIT = 5;

    // Status register fields
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_XSTB_BIT = 3;
    localparam int STAT_CPUGATE_BIT = 4;
    localparam int STAT_ONXTAL_BIT = 5;
    localparam int STAT_IOHOLD_BIT = 6;

    // Reset values
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic CLKSRC_RESET = 1'h1;
    localparam logic SLOWSRC_RESET = 1'h1;
    localparam logic USB_RESET = 1'h0;

    // Sleep-mode field codes
    localparam logic [1:0] SEL_CPU_IDLE = 2'h0;
    localparam logic [1:0] SEL_LIGHT = 2'h1;
    localparam logic [1:0] SEL_DEEP = 2'h2;
    localparam logic [1:0] SEL_LOWEST = 2'h3;

    // Clock source select: 0 picks the crystal oscillator
    localparam logic CLKSRC_CRYSTAL = 1'h0;
    // Low-speed select: 1 picks the slow RC oscillator
    localparam logic SLOWSRC_RC = 1'h1;

    ////////////////////////////////////////////////////////////////////////
    // Power-down and power-up sequence lengths
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEQ_FAST_NS = 40;
    localparam int SEQ_SLOW_NS = 200;
    localparam int SEQ_FAST_CYC = (SEQ_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEQ_SLOW_CYC = (SEQ_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        PMC_ACTIVE,
        PMC_CPU_IDLE,
        PMC_PWR_DOWN,
        PMC_LIGHT,
        PMC_DEEP,
        PMC_LOWEST,
        PMC_PWR_UP
    } pmc_state_t;

    typedef struct packed {
        logic core_reg;
        logic crystal;
        logic fast_rc;
        logic slow_rc;
        logic crystal_32k;
        logic cpu_clk;
    } pmc_enables_t;

    localparam pmc_enables_t EN_RESET = '{core_reg: 1'h1, crystal: 1'h0, fast_rc: 1'h1,
                                          slow_rc: 1'h1, crystal_32k: 1'h0, cpu_clk: 1'h1};

endpackage : pmc_pkg

/* File: pmc_sync.sv */
`timescale 1ns/1ps

module pmc_sync #(
    parameter int W = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] stage1;

    // First stage feeds only the second one
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            stage1 <= '0;
            o_sync <= '0;
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule : pmc_sync

/* File: pmc_seq_cnt.sv */
`timescale 1ns/1ps

module pmc_seq_cnt #(
    parameter int W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [W-1:0] i_load,
    output logic o_done
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic busy;
    logic next_busy;
    logic next_done;

    always_comb
    begin
        next_count = count;
        next_busy = busy;
        next_done = 1'b0;
        if (i_start)
        begin
            next_count = i_load;
            next_busy = 1'b1;
        end
        else if (busy)
        begin
            if (count <= {{(W-1){1'b0}}, 1'b1})
            begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
            else
            begin
                next_count = count - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            count <= '0;
            busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            count <= next_count;
            busy <= next_busy;
            o_done <= next_done;
        end
    end

endmodule : pmc_seq_cnt

/* File: pmc_monitor.sv */
`timescale 1ns/1ps

module pmc_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_ext_wake,
    input wire logic i_crystal_stable_flag,
    input pmc_pkg::pmc_enables_t o_en,
    input wire logic o_sys_clk_on_crystal,
    input wire logic o_io_hold,
    input wire logic o_usb_reset,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_access;
        i_psel && !i_penable ##1 i_psel && i_penable && !o_pready;
    endsequence
    sequence s_idle_taken;
        i_psel && i_penable && o_pready && i_pwrite && i_paddr == pmc_pkg::CTRL_OFFSET
            && i_pwdata[pmc_pkg::CTRL_IDLE_BIT] && o_en.cpu_clk;
    endsequence
    // Sync plus registered decision needs several quiet samples
    sequence s_lowest_quiet;
        (!o_en.core_reg && !o_en.slow_rc && !o_en.crystal_32k && !i_ext_wake) [*6];
    endsequence

    a_apb_wait: assert property (s_access |=> o_pready)
        else $error("ready not one cycle after access");
    a_ready_once: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_bad_addr: assert property (o_pready && i_paddr != pmc_pkg::CTRL_OFFSET
        && i_paddr != pmc_pkg::STATUS_OFFSET |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    a_idle_gate: assert property (s_idle_taken |=> !o_en.cpu_clk)
        else $error("idle request did not gate cpu clock");
    a_run_needs: assert property (o_en.cpu_clk |-> o_en.core_reg && o_en.fast_rc)
        else $error("cpu runs without regulator or fast clock");
    a_one_slow: assert property (o_en.slow_rc |-> !o_en.crystal_32k)
        else $error("two slow sources on");
    a_reg_off: assert property (!o_en.core_reg |->
        !o_en.fast_rc && !o_en.crystal && o_io_hold)
        else $error("regulator off with fast clocks on");
    a_hold_gated: assert property (o_io_hold |-> !o_en.cpu_clk)
        else $error("pins held while cpu runs");
    a_usb_pulse: assert property (o_usb_reset |-> !o_en.cpu_clk ##1 !o_usb_reset)
        else $error("usb reset not a single pulse in sleep entry");
    a_xtal_wait: assert property ((!i_crystal_stable_flag) [*5] |->
        !o_sys_clk_on_crystal)
        else $error("crystal used before stable");
    a_lowest_still: assert property (s_lowest_quiet |=> !o_en.fast_rc)
        else $error("lowest mode left without external wake");
endmodule : pmc_monitor

bind pmc_top pmc_monitor pmc_monitor_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_ext_wake(i_ext_wake), .i_crystal_stable_flag(i_crystal_stable_flag),
    .o_en(o_en), .o_sys_clk_on_crystal(o_sys_clk_on_crystal), .o_io_hold(o_io_hold),
    .o_usb_reset(o_usb_reset), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr));

/* File: pmc_partner.sv */
`timescale 1ns/1ps

module pmc_partner #(
    parameter int STABLE_CYC = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input pmc_pkg::pmc_enables_t i_en,
    input wire logic i_timer_arm,
    input wire logic [7:0] i_timer_load,
    output logic o_timer_expired,
    output logic o_crystal_stable_flag
);
    int xtal_cnt;
    logic [7:0] tmr;

    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            xtal_cnt <= 0;
            tmr <= 8'h00;
        end
        else
        begin
            // Flag drops at once when the crystal stops
            xtal_cnt <= i_en.crystal ? xtal_cnt + 1 : 0;
            if (!i_timer_arm)
                tmr <= i_timer_load;
            else if ((i_en.slow_rc || i_en.crystal_32k) && tmr != 8'h00)
                tmr <= tmr - 8'h01;
        end
    end
    assign o_crystal_stable_flag = xtal_cnt >= STABLE_CYC;
    // Timer counts only on a running slow source
    assign o_timer_expired = i_timer_arm && tmr == 8'h00;
endmodule : pmc_partner

/* File: tb_pmc_top.sv */
`timescale 1ns/1ps

module tb_pmc_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic irq = 1'b0;
    logic ext = 1'b0;
    logic arm = 1'b0;
    logic [7:0] tload = 8'hFF;
    logic tmr_exp, xstb, on_xtal, io_hold, usb_rst, resume, restart, pready, err, perr;
    logic [31:0] prdata, rd;
    pmc_pkg::pmc_enables_t en;
    int miscompares = 0;
    int n_checks = 0;
    int n_resume = 0;
    int n_usb = 0;

    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        n_resume <= n_resume + int'(resume === 1'b1);
        n_usb <= n_usb + int'(usb_rst === 1'b1);
    end

    pmc_top #(.SEQ_W(8)) pmc_top_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_irq_any(irq), .i_ext_wake(ext), .i_sleep_timer_expired(tmr_exp),
        .i_crystal_stable_flag(xstb), .o_en(en), .o_sys_clk_on_crystal(on_xtal),
        .o_io_hold(io_hold), .o_usb_reset(usb_rst), .o_cpu_resume(resume),
        .o_cpu_restart(restart), .o_pready(pready), .o_prdata(prdata), .o_pslverr(perr));
    pmc_partner pmc_partner_i (.i_clk_sys(clk), .i_rst_b(rst_b), .i_en(en),
        .i_timer_arm(arm), .i_timer_load(tload), .o_timer_expired(tmr_exp),
        .o_crystal_stable_flag(xstb));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No local limit: only the watchdog ends a stuck transfer
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Index 7 io hold, 6 on crystal, 5..0 enables
    task automatic wait_for(input int i, input logic v);
        int n;
        logic [7:0] s;
        n = 0;
        s = {io_hold, on_xtal, en};
        while (s[i] !== v && n < 300)
        begin
            @(posedge clk);
            #1;
            s = {io_hold, on_xtal, en};
            n++;
        end
        if (n >= 300)
            miscompares++;
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, pmc_pkg::CTRL_OFFSET, 32'h0);
        check(rd, 32'h18);
        apb(1'b1, pmc_pkg::STATUS_OFFSET, 32'h7);
        check(err, 1'b0);
        apb(1'b0, pmc_pkg::STATUS_OFFSET, 32'h0);
        check(rd[2:0], 3'h0);
        apb(1'b0, 12'h008, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
    endtask : t_regs

    task automatic t_idle;
        int r0;
        r0 = n_resume;
        apb(1'b1, pmc_pkg::CTRL_OFFSET, 32'h18);
        apb(1'b1, pmc_pkg::CTRL_OFFSET, 32'h1C);
        #1 check(en, 6'h2C);
        apb(1'b0, pmc_pkg::STATUS_OFFSET, 32'h0);
        check(rd[4:0], 5'h11);
        @(posedge clk);
        irq <= 1'b1;
        wait_for(0, 1'b1);
        @(posedge clk);
        irq <= 1'b0;
        repeat (2) @(posedge clk);
        check(n_resume - r0, 1);
    endtask : t_idle

    // c: clock and slow source bits, m: mode, tmr: wake by sleep timer
    task automatic t_sleep(input logic [31:0] c, input logic [1:0] m, input logic tmr);
        int r0, u0;
        logic [5:0] slow, exp;
        r0 = n_resume;
        u0 = n_usb;
        slow = c[4] ? 6'h04 : 6'h02;
        exp = m == pmc_pkg::SEL_LIGHT ? 6'h20 | slow : m == pmc_pkg::SEL_DEEP ? slow : 6'h00;
        tload <= m == pmc_pkg::SEL_LOWEST ? 8'h00 : tmr ? 8'h3C : 8'hFF;
        apb(1'b1, pmc_pkg::CTRL_OFFSET, c | 32'h20 | m);
        arm <= 1'b1;
        apb(1'b1, pmc_pkg::CTRL_OFFSET, c | 32'h24 | m);
        wait_for(7, 1'b1);
        check(en, exp);
        apb(1'b0, pmc_pkg::CTRL_OFFSET, 32'h0);
        check(rd[1:0], 2'h0);
        check(rd[5], m == pmc_pkg::SEL_LIGHT);
        if (!tmr)
        begin
            repeat (20) @(posedge clk);
            #1 check({io_hold, en}, {1'b1, exp});
            @(posedge clk);
            ext <= 1'b1;
        end
        wait_for(0, 1'b1);
        @(posedge clk);
        ext <= 1'b0;
        arm <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(n_resume - r0, 1);
        check(n_usb - u0, int'(m != pmc_pkg::SEL_LIGHT));
        exp = 6'h29 | slow | (c[3] ? 6'h00 : 6'h10);
        check({restart, on_xtal, en}, {2'b00, exp});
        apb(1'b0, pmc_pkg::CTRL_OFFSET, 32'h0);
        check(rd[2:0], 3'h0);
    endtask : t_sleep

    task automatic t_crystal;
        apb(1'b1, pmc_pkg::CTRL_OFFSET, 32'h00);
        #1 check({on_xtal, en}, 7'h3B);
        wait_for(6, 1'b1);
        t_sleep(32'h00, pmc_pkg::SEL_LIGHT, 1'b0);
        wait_for(6, 1'b1);
    endtask : t_crystal

    task automatic t_reset_mid;
        apb(1'b1, pmc_pkg::CTRL_OFFSET, 32'h3A);
        apb(1'b1, pmc_pkg::CTRL_OFFSET, 32'h3E);
        wait_for(7, 1'b1);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        #1 check({restart, en}, 7'h6D);
        @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 check({restart, io_hold, en}, 8'h2D);
        apb(1'b0, pmc_pkg::CTRL_OFFSET, 32'h0);
        check(rd, 32'h18);
    endtask : t_reset_mid

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        #1 check({restart, en}, 7'h6D);
        @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_idle();
        t_sleep(32'h18, pmc_pkg::SEL_LIGHT, 1'b1);
        t_sleep(32'h18, pmc_pkg::SEL_LIGHT, 1'b0);
        t_sleep(32'h18, pmc_pkg::SEL_DEEP, 1'b1);
        t_sleep(32'h18, pmc_pkg::SEL_LOWEST, 1'b0);
        t_crystal();
        t_reset_mid();
        test_done();
    end

    // Whole run is a few hundred cycles
    initial
    begin
        #200000;
        miscompares++;
        test_done();
    end
endmodule : tb_pmc_top
